// ===== sfl_pkg.sv
// Constants and types for the serial flash link front end and operation timer
package sfl_pkg;
    // Core clock rate
    localparam int unsigned CLK_MHZ              = 25;

    // Times as printed, in their own units
    localparam int unsigned SELECT_TO_PENDING_NS = 100;
    localparam int unsigned PROTECT_ON_US        = 1;
    localparam int unsigned PROTECT_OFF_US       = 1;
    localparam int unsigned SLEEP_ENTRY_US       = 3;
    localparam int unsigned SLEEP_EXIT_US        = 35;
    localparam int unsigned PAGE_TRANSFER_US     = 200;
    localparam int unsigned PAGE_COMPARE_US      = 200;
    localparam int unsigned ERASE_PROG_MS        = 40;
    localparam int unsigned PROG_MS              = 6;
    localparam int unsigned PAGE_ERASE_MS        = 35;
    localparam int unsigned BLOCK_ERASE_MS       = 100;
    localparam int unsigned SECTOR_ERASE_S       = 5;
    localparam int unsigned RESET_RECOVERY_US    = 1;

    // All times round down to whole cycles, never below one
    function automatic int unsigned at_least_one(input int unsigned c);
        at_least_one = (c == 0) ? 1 : c;
    endfunction

    localparam int unsigned SELECT_TO_PENDING_CYC = at_least_one(SELECT_TO_PENDING_NS * CLK_MHZ / 1000);
    localparam int unsigned PROTECT_ON_CYC        = at_least_one(PROTECT_ON_US * CLK_MHZ);
    localparam int unsigned PROTECT_OFF_CYC       = at_least_one(PROTECT_OFF_US * CLK_MHZ);
    localparam int unsigned SLEEP_ENTRY_CYC       = at_least_one(SLEEP_ENTRY_US * CLK_MHZ);
    localparam int unsigned SLEEP_EXIT_CYC        = at_least_one(SLEEP_EXIT_US * CLK_MHZ);
    localparam int unsigned PAGE_TRANSFER_CYC     = at_least_one(PAGE_TRANSFER_US * CLK_MHZ);
    localparam int unsigned PAGE_COMPARE_CYC      = at_least_one(PAGE_COMPARE_US * CLK_MHZ);
    localparam int unsigned ERASE_PROG_CYC        = at_least_one(ERASE_PROG_MS * 1000 * CLK_MHZ);
    localparam int unsigned PROG_CYC              = at_least_one(PROG_MS * 1000 * CLK_MHZ);
    localparam int unsigned PAGE_ERASE_CYC        = at_least_one(PAGE_ERASE_MS * 1000 * CLK_MHZ);
    localparam int unsigned BLOCK_ERASE_CYC       = at_least_one(BLOCK_ERASE_MS * 1000 * CLK_MHZ);
    localparam int unsigned SECTOR_ERASE_CYC      = at_least_one(SECTOR_ERASE_S * 1000000 * CLK_MHZ);
    localparam int unsigned RESET_RECOVERY_CYC    = at_least_one(RESET_RECOVERY_US * CLK_MHZ);

    // Link framing
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned TIMER_W     = 27;
    // Synchroniser order {reset_pin_n, wp_n, si, sck, cs_n}; idle pin levels
    localparam logic [4:0]  SYNC_RST    = 5'h19;
    localparam logic [2:0]  BIT_LAST    = 3'h7;

    typedef enum logic [3:0] {
        SFL_OP_NONE   = 4'h0,
        SFL_OP_XFER   = 4'h1,
        SFL_OP_COMP   = 4'h2,
        SFL_OP_EPROG  = 4'h3,
        SFL_OP_PROG   = 4'h4,
        SFL_OP_PERASE = 4'h5,
        SFL_OP_BERASE = 4'h6,
        SFL_OP_SERASE = 4'h7,
        SFL_OP_SLEEP  = 4'h8,
        SFL_OP_WAKE   = 4'h9
    } sfl_op_t;

    typedef enum logic [1:0] {
        SFL_ST_IDLE    = 2'h0,
        SFL_ST_RUN     = 2'h1,
        SFL_ST_SLEEP   = 2'h2,
        SFL_ST_RECOVER = 2'h3
    } sfl_state_t;
endpackage

// ===== sfl_sync.sv
// Two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
module sfl_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule

// ===== sfl_dev.sv
// Serial flash link: bit shifting, ready/busy, protect, sleep and operation timing
`timescale 1ns/10ps
module sfl_dev
    import sfl_pkg::*;
#(
    parameter int unsigned CW         = TIMER_W,
    parameter int unsigned XFER_CYC   = PAGE_TRANSFER_CYC,
    parameter int unsigned COMP_CYC   = PAGE_COMPARE_CYC,
    parameter int unsigned EPROG_CYC  = ERASE_PROG_CYC,
    parameter int unsigned PROGR_CYC  = PROG_CYC,
    parameter int unsigned PERASE_CYC = PAGE_ERASE_CYC,
    parameter int unsigned BERASE_CYC = BLOCK_ERASE_CYC,
    parameter int unsigned SERASE_CYC = SECTOR_ERASE_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wp_n,
    input  wire logic       reset_pin_n,
    input  wire logic [7:0] tx_byte,
    input  wire sfl_op_t    op_arm,
    output logic            so,
    output logic            so_oe,
    output logic            ready,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            rx_first,
    output logic            tx_take,
    output logic            protect_on,
    output logic            sleeping,
    output logic            op_done
);
    initial begin
        if (CW < 2 || CW > 31 || (longint'(SERASE_CYC) >= (64'h1 << CW))
            || (longint'(EPROG_CYC) >= (64'h1 << CW))
            || (longint'(BERASE_CYC) >= (64'h1 << CW))) begin
            $error("sfl_dev: timer width too small for the durations");
        end
    end

    logic [4:0]    pin_s;
    logic          cs_s;
    logic          sck_s;
    logic          si_s;
    logic          wp_s;
    logic          rst_s;
    logic          cs_d_r;
    logic          sck_d_r;
    logic          si_d_r;
    logic [7:0]    rx_sh_r;
    logic [7:0]    tx_sh_r;
    logic [2:0]    bit_cnt_r;
    logic [2:0]    out_cnt_r;
    logic          first_r;
    sfl_state_t    state_r;
    sfl_op_t       op_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] elapsed_r;

    sfl_sync #(
        .W       (5),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      ({reset_pin_n, wp_n, si, sck, cs_n}),
        .dout     (pin_s)
    );

    assign cs_s  = pin_s[0];
    assign sck_s = pin_s[1];
    assign si_s  = pin_s[2];
    assign wp_s  = pin_s[3];
    assign rst_s = pin_s[4];

    // Edge detection on the synchronised link pins
    wire selected = ~cs_s & rst_s;
    wire cs_fall  = cs_d_r & ~cs_s;
    wire cs_rise  = ~cs_d_r & cs_s;
    wire sck_rise = selected & sck_s & ~sck_d_r;
    wire sck_fall = selected & ~sck_s & sck_d_r;

    // Operations that hold the ready line low
    wire arm_busy = (op_arm != SFL_OP_NONE) && (op_arm != SFL_OP_SLEEP)
                    && (op_arm != SFL_OP_WAKE);
    wire arm_go   = cs_rise && (state_r == SFL_ST_IDLE) && (op_arm != SFL_OP_NONE)
                    && (op_arm != SFL_OP_WAKE);
    wire wake_go  = cs_rise && (state_r == SFL_ST_SLEEP) && (op_arm == SFL_OP_WAKE);

    wire [CW-1:0] dur_sel =
        (op_r == SFL_OP_XFER)   ? CW'(XFER_CYC)        :
        (op_r == SFL_OP_COMP)   ? CW'(COMP_CYC)        :
        (op_r == SFL_OP_EPROG)  ? CW'(EPROG_CYC)       :
        (op_r == SFL_OP_PROG)   ? CW'(PROGR_CYC)       :
        (op_r == SFL_OP_PERASE) ? CW'(PERASE_CYC)      :
        (op_r == SFL_OP_BERASE) ? CW'(BERASE_CYC)      :
        (op_r == SFL_OP_SERASE) ? CW'(SERASE_CYC)      :
        (op_r == SFL_OP_SLEEP)  ? CW'(SLEEP_ENTRY_CYC) :
                                  CW'(SLEEP_EXIT_CYC);
    wire [CW-1:0] dur_last = dur_sel - CW'(1);
    wire          run_end  = (state_r == SFL_ST_RUN) && (cnt_r == dur_last);
    wire          rec_end  = (state_r == SFL_ST_RECOVER) && rst_s
                             && (cnt_r == CW'(RESET_RECOVERY_CYC - 1));

    // Delayed copies; si is taken one cycle late so a bit launched on
    // the same rise cannot race the sample
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
            si_d_r  <= 1'b0;
        end else begin
            cs_d_r  <= cs_s;
            sck_d_r <= sck_s;
            si_d_r  <= si_s;
        end
    end

    // Receive shifter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_sh_r   <= 8'h00;
            bit_cnt_r <= 3'h0;
            first_r   <= 1'b0;
            rx_byte   <= 8'h00;
            rx_valid  <= 1'b0;
            rx_first  <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (cs_fall) begin
                bit_cnt_r <= 3'h0;
                first_r   <= 1'b1;
            end else if (sck_rise) begin
                rx_sh_r   <= {rx_sh_r[6:0], si_d_r};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == BIT_LAST) begin
                    rx_byte  <= {rx_sh_r[6:0], si_d_r};
                    rx_valid <= 1'b1;
                    rx_first <= first_r;
                    first_r  <= 1'b0;
                end
            end
        end
    end

    // Transmit shifter; each fall launches the next bit for the low phase
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_r   <= 8'h00;
            out_cnt_r <= 3'h0;
            so        <= 1'b0;
            so_oe     <= 1'b0;
            tx_take   <= 1'b0;
        end else begin
            tx_take <= 1'b0;
            so_oe   <= selected;
            if (cs_fall) begin
                tx_sh_r   <= tx_byte;
                out_cnt_r <= 3'h0;
            end else if (sck_fall) begin
                so        <= tx_sh_r[7];
                out_cnt_r <= out_cnt_r + 3'h1;
                if (out_cnt_r == BIT_LAST) begin
                    tx_sh_r <= tx_byte;
                    tx_take <= 1'b1;
                end else begin
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    // Protection tracks the pin well inside the allowed microsecond
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            protect_on <= 1'b0;
        end else begin
            protect_on <= ~wp_s;
        end
    end

    // Operation timer and ready line
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r  <= SFL_ST_RECOVER;
            op_r     <= SFL_OP_NONE;
            cnt_r    <= '0;
            ready    <= 1'b0;
            sleeping <= 1'b0;
            op_done  <= 1'b0;
        end else begin
            op_done <= 1'b0;
            if (!rst_s) begin
                state_r  <= SFL_ST_RECOVER;
                cnt_r    <= '0;
                ready    <= 1'b0;
                sleeping <= 1'b0;
            end else begin
                case (state_r)
                    SFL_ST_IDLE: begin
                        if (arm_go) begin
                            state_r <= SFL_ST_RUN;
                            op_r    <= op_arm;
                            cnt_r   <= '0;
                            ready   <= ~arm_busy;
                        end
                    end
                    SFL_ST_RUN: begin
                        cnt_r <= cnt_r + CW'(1);
                        if (run_end) begin
                            op_done <= 1'b1;
                            if (op_r == SFL_OP_SLEEP) begin
                                state_r  <= SFL_ST_SLEEP;
                                sleeping <= 1'b1;
                            end else begin
                                state_r  <= SFL_ST_IDLE;
                                sleeping <= 1'b0;
                                ready    <= 1'b1;
                            end
                        end
                    end
                    SFL_ST_SLEEP: begin
                        if (wake_go) begin
                            state_r <= SFL_ST_RUN;
                            op_r    <= SFL_OP_WAKE;
                            cnt_r   <= '0;
                        end
                    end
                    SFL_ST_RECOVER: begin
                        cnt_r <= cnt_r + CW'(1);
                        if (rec_end) begin
                            state_r <= SFL_ST_IDLE;
                            ready   <= 1'b1;
                        end
                    end
                    default: begin
                        state_r <= SFL_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Length of the current timed run, watched by the checks below
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            elapsed_r <= '0;
        end else if (state_r == SFL_ST_RUN) begin
            elapsed_r <= elapsed_r + CW'(1);
        end else begin
            elapsed_r <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_rx_on_rise: assert property (rx_valid |-> $past(sck_rise))
        else $error("byte completed without a clock rise");
    a_so_on_fall: assert property (!$stable(so) |-> $past(sck_fall))
        else $error("serial output changed away from a clock fall");
    a_so_msb_out: assert property (sck_fall |=> so == $past(tx_sh_r[7]))
        else $error("output bit not presented after the fall");
    a_select_restart: assert property (cs_fall |=> bit_cnt_r == 3'h0 && out_cnt_r == 3'h0)
        else $error("frame start did not realign bit counters");
    a_busy_on_rise: assert property (arm_go && arm_busy && rst_s |=> !ready ##1 !ready)
        else $error("ready not dropped after select rise");
    a_protect_track: assert property ($fell(wp_n) |-> ##[1:4] protect_on)
        else $error("protection late after pin fell");
    a_protect_release: assert property ($rose(wp_n) |-> ##[1:4] !protect_on)
        else $error("protection not released after pin rose");
    a_sleep_entry: assert property (run_end && op_r == SFL_OP_SLEEP && rst_s |=> sleeping)
        else $error("sleep not entered at end of entry time");
    a_xfer_length: assert property ((state_r == SFL_ST_IDLE) && $past(state_r == SFL_ST_RUN)
        && ($past(op_r) == SFL_OP_XFER || $past(op_r) == SFL_OP_COMP)
        |-> $past(elapsed_r) == (($past(op_r) == SFL_OP_COMP) ? CW'(COMP_CYC - 1)
                                                             : CW'(XFER_CYC - 1)) && ready)
        else $error("transfer or compare length wrong");
    a_prog_length: assert property (op_done && ($past(op_r) == SFL_OP_PROG)
        |-> $past(elapsed_r) == CW'(PROGR_CYC - 1))
        else $error("program length wrong");
    a_erase_length: assert property (op_done && ($past(op_r) == SFL_OP_BERASE)
        |-> $past(elapsed_r) == CW'(BERASE_CYC - 1))
        else $error("block erase length wrong");
    a_reset_hold: assert property (!rst_s |=> state_r == SFL_ST_RECOVER && !ready)
        else $error("reset pin did not hold the device");
    a_byte_eight: assert property (rx_valid |-> $past(bit_cnt_r) == BIT_LAST)
        else $error("byte did not take eight clocks");
endmodule

// ===== sfl_host.sv
// Host controller model for the serial flash link: select, clock, data and reset pins
`timescale 1ns/10ps
module sfl_host (
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      reset_pin_n,
    input  wire logic so
);
    // Half of the 320 ns link clock, far under every clock ceiling
    localparam int HALF_NS = 160;

    initial begin
        cs_n        = 1'b1;
        sck         = 1'b0;
        si          = 1'b1;
        reset_pin_n = 1'b1;
    end

    // One two-byte frame; mode3 picks the idle clock level. Every fall launches a bit
    // and the host takes it at the next fall, the last one just before select rises
    task automatic frame(input logic mode3, input logic [15:0] dout, output logic [15:0] din);
        int falls;
        falls = 0;
        din   = 16'h0000;
        #7; // Off the core clock edges so no pin change races the synchronisers
        sck = mode3;
        #(HALF_NS); // deselect gap well over 50 ns
        si   = dout[15]; // first bit set up before the first rise
        cs_n = 1'b0;
        #(HALF_NS);
        for (int i = 15; i >= 0; i--) begin
            if (sck) begin
                if (falls > 0) begin
                    din = {din[14:0], so}; // bit launched at the fall before
                end
                falls++;
            end
            sck = 1'b0;
            #(HALF_NS);
            sck = 1'b1;
            si  = (i > 0) ? dout[i-1] : ~dout[0]; // next bit launched on the rise
            #(HALF_NS);
        end
        if (!mode3) begin
            din = {din[14:0], so};
            sck = 1'b0;
            #(HALF_NS);
        end
        #(HALF_NS);
        din  = {din[14:0], so}; // bit launched at the last fall
        cs_n = 1'b1;
        // Released data line must not keep showing the last bit
        si = ~si;
    endtask

    task automatic hw_reset(input int low_ns);
        cs_n        = 1'b1; // select high across the reset release
        reset_pin_n = 1'b0;
        #(low_ns); // held low at least 10 us
        reset_pin_n = 1'b1;
    endtask
endmodule

// ===== serial_flash_link_timing_tb.sv
// Self-checking bench for the serial flash link front end and operation timer
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("ERROR %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module serial_flash_link_timing_tb
    import sfl_pkg::*;
;
    logic       core_clk;
    logic       rstn;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       wp_n;
    logic       reset_pin_n;
    logic [7:0] tx_byte;
    logic [7:0] tx_alt;
    sfl_op_t    op_arm;
    logic       so;
    logic       so_oe;
    logic       ready;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_first;
    logic       tx_take;
    logic       protect_on;
    logic       sleeping;
    logic       op_done;
    logic       oe_d;
    logic       oe_seen;
    logic [8:0] rxq[$];
    int         fails;
    int         comparisons;

    // Transfer and compare keep their real length; the long erase and program runs
    // are cut short so op code k from 3 up lasts 32 + 8k cycles
    sfl_dev #(.EPROG_CYC(56), .PROGR_CYC(64),
              .PERASE_CYC(72), .BERASE_CYC(80), .SERASE_CYC(88)) sfl_dev_i (
        .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .reset_pin_n(reset_pin_n), .tx_byte(tx_byte), .op_arm(op_arm), .so(so),
        .so_oe(so_oe), .ready(ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_first(rx_first), .tx_take(tx_take), .protect_on(protect_on),
        .sleeping(sleeping), .op_done(op_done));

    sfl_host sfl_host_i (.cs_n(cs_n), .sck(sck), .si(si), .reset_pin_n(reset_pin_n), .so(so));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // The frame start loads the first byte with no pulse, so the second goes up
    // as soon as the enable rises; later ones follow each take pulse
    always @(posedge core_clk) begin
        oe_d <= so_oe;
        if (tx_take === 1'b1 || (so_oe === 1'b1 && oe_d !== 1'b1)) begin
            tx_byte <= tx_alt;
        end
        if (so_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
        if (rx_valid === 1'b1) begin
            rxq.push_back({rx_first, rx_byte});
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_done(input int limit, output int cnt);
        cnt = 0;
        while (op_done !== 1'b1 && cnt < limit) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic t_link(input logic mode3, input logic [15:0] mo, input logic [15:0] dv);
        logic [15:0] got;
        @(posedge core_clk);
        tx_byte <= dv[15:8];
        tx_alt  <= dv[7:0];
        rxq.delete();
        oe_seen <= 1'b0;
        @(posedge core_clk);
        sfl_host_i.frame(mode3, mo, got);
        repeat (6) @(posedge core_clk);
        #1;
        `CHK("enable seen", 1'b1, oe_seen)
        `CHK("enable released", 1'b0, so_oe)
        `CHK("serial out", dv, got)
        `CHK("rx count", 2, rxq.size())
        `CHK("rx first", {1'b1, mo[15:8]}, rxq[0])
        `CHK("rx second", {1'b0, mo[7:0]}, rxq[1])
        $display("test link mode %0d done", mode3 ? 3 : 0);
    endtask

    task automatic t_op(input sfl_op_t op);
        logic [15:0] got;
        int          cnt;
        int          want;
        logic        low_ok;
        want = (op == SFL_OP_XFER) ? int'(PAGE_TRANSFER_CYC) :
               (op == SFL_OP_COMP) ? int'(PAGE_COMPARE_CYC) : 32 + 8 * int'(op);
        @(posedge core_clk);
        op_arm <= op;
        sfl_host_i.frame(1'b0, 16'h9E61, got);
        cnt = 0;
        while (ready === 1'b1 && cnt < 8) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        `CHK("busy delay", 1'b1, cnt <= 5)
        @(posedge core_clk);
        op_arm <= SFL_OP_NONE;
        #1;
        cnt    = 1;
        low_ok = 1'b1;
        while (op_done !== 1'b1 && cnt < want + 20) begin
            low_ok &= (ready === 1'b0);
            @(posedge core_clk);
            #1;
            cnt++;
        end
        `CHK("run length", want, cnt)
        `CHK("busy held", 1'b1, low_ok)
        `CHK("ready at end", 1'b1, ready)
        $display("test op %0d done", op);
    endtask

    task automatic t_sleep;
        logic [15:0] got;
        int          cnt;
        @(posedge core_clk);
        op_arm <= SFL_OP_SLEEP;
        sfl_host_i.frame(1'b1, 16'h5AA5, got);
        wait_done(200, cnt);
        `CHK("sleep entry", 1'b1, cnt >= SLEEP_ENTRY_CYC + 2 && cnt <= SLEEP_ENTRY_CYC + 6)
        `CHK("asleep", 1'b1, sleeping)
        @(posedge core_clk);
        op_arm <= SFL_OP_XFER;
        sfl_host_i.frame(1'b0, 16'h1234, got);
        repeat (20) @(posedge core_clk);
        #1;
        `CHK("arm refused", 1'b1, ready & sleeping)
        @(posedge core_clk);
        op_arm <= SFL_OP_WAKE;
        sfl_host_i.frame(1'b0, 16'hABCD, got);
        wait_done(1000, cnt);
        `CHK("sleep exit", 1'b1, cnt >= SLEEP_EXIT_CYC + 2 && cnt <= SLEEP_EXIT_CYC + 6)
        `CHK("awake", 1'b0, sleeping)
        @(posedge core_clk);
        op_arm <= SFL_OP_NONE;
        $display("test sleep done");
    endtask

    task automatic t_protect;
        @(posedge core_clk);
        wp_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("protect on", 1'b1, protect_on)
        @(posedge core_clk);
        wp_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("protect off", 1'b0, protect_on)
        $display("test protect done");
    endtask

    task automatic t_reset;
        int cnt;
        fork
            sfl_host_i.hw_reset(10000);
            begin
                repeat (100) @(posedge core_clk);
                #1;
                `CHK("ready in reset", 1'b0, ready)
            end
        join
        cnt = 0;
        while (ready !== 1'b1 && cnt < 60) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        `CHK("recovery", 1'b1, cnt >= RESET_RECOVERY_CYC && cnt <= RESET_RECOVERY_CYC + 5)
        $display("test reset done");
    endtask

    initial begin
        fails       = 0;
        comparisons = 0;
        rstn    <= 1'b0;
        wp_n    <= 1'b1;
        tx_byte <= 8'h00;
        tx_alt  <= 8'h00;
        op_arm  <= SFL_OP_NONE;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (40) @(posedge core_clk);
        t_link(1'b0, 16'hC35A, 16'hA53C);
        t_link(1'b1, 16'h00FF, 16'h81FE);
        for (int k = 1; k <= 7; k++) begin
            t_op(sfl_op_t'(k[3:0]));
        end
        t_sleep();
        t_protect();
        t_reset();
        report_and_stop();
    end

    // Whole run needs about 14,000 cycles; the limit allows 50,000
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
endmodule
